// [rtl/eprom_port_pkg.sv]
// constants for the code eprom program and verify port
package eprom_port_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int KEY_W = 6;
  localparam int KEY_DEPTH = 64;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // mode select code, bit 4 is select 4 ... bit 0 is select 0
  localparam logic [4:0] SEL_PROG_CODE = 5'h1e;
  localparam logic [4:0] SEL_VERIFY = 5'h18;
  localparam logic [4:0] SEL_PROG_KEY = 5'h16;
  localparam logic [4:0] SEL_LOCK_1 = 5'h1f;
  localparam logic [4:0] SEL_LOCK_2 = 5'h07;
  localparam logic [4:0] SEL_LOCK_3 = 5'h0d;
  localparam logic [4:0] SEL_SIGNATURE = 5'h00;
  // signature locations
  localparam logic [13:0] SIG_ADDR_0 = 14'h0030;
  localparam logic [13:0] SIG_ADDR_1 = 14'h0031;
  localparam logic [13:0] SIG_ADDR_2 = 14'h0060;
  // identity bytes: values are arbitrary
  localparam logic [7:0] SIG_BYTE_0 = 8'h11;
  localparam logic [7:0] SIG_BYTE_1 = 8'h22;
  localparam logic [7:0] SIG_BYTE_2 = 8'h33;
  typedef enum logic [2:0] {
    MODE_IDLE, MODE_PROG_CODE, MODE_VERIFY, MODE_PROG_KEY,
    MODE_LOCK_1, MODE_LOCK_2, MODE_LOCK_3, MODE_SIGNATURE
  } mode_t;
endpackage

// [rtl/prog_mode_decode.sv]
// decodes the static control levels into a programming mode
`timescale 1ns/1ps
module prog_mode_decode
  import eprom_port_pkg::*;
(
  // control levels
  input wire logic reset_level_in,
  input wire logic program_store_enable_n_in,
  input wire logic [4:0] mode_select_in,
  // decoded mode
  output mode_t mode_out
);
  always_comb begin
    mode_out = MODE_IDLE;
    if (reset_level_in && !program_store_enable_n_in) begin
      case (mode_select_in)
        SEL_PROG_CODE: mode_out = MODE_PROG_CODE;
        SEL_VERIFY: mode_out = MODE_VERIFY; // [R10]
        SEL_PROG_KEY: mode_out = MODE_PROG_KEY; // [R11]
        SEL_LOCK_1: mode_out = MODE_LOCK_1; // [R12]
        SEL_LOCK_2: mode_out = MODE_LOCK_2;
        SEL_LOCK_3: mode_out = MODE_LOCK_3;
        SEL_SIGNATURE: mode_out = MODE_SIGNATURE; // [R17]
        default: mode_out = MODE_IDLE; // [R21]
      endcase
    end
  end
endmodule

// [rtl/eprom_program_verify_port.sv]
// program and verify port of the on-chip code eprom
// Function
// [R1] programmer clocks device at 4 to 6 MHz
// [R2] 14-bit address on ports 1, 2, 3
// [R3] port 0 carries data both ways
// [R4] reset high, store enable low, selects static
// [R5] address, data, mode, then raise supply
// [R6] code program: select 0 low, others high
// [R7] supply raised only around the strobe
// [R8] 5 pulses code, 25 key and lock
// [R9] sequence repeats per address until done
// [R10] verify mode outputs addressed code byte
// [R11] key array program mode, addresses 0-3fh
// [R12] three lock bits with own select codes
// [R13] lock bits cannot be read back
// [R14] erase clears code, key array, locks; here erase_in clears only key array and locks
// [R15] verify output is code xnor key byte
// [R16] key array erases to all ones
// [R17] signature mode with all selects low
// [R18] signature bytes at 30h, 31h, 60h
// [R19] lock levels restrict read, program, verify
// [R20] writes only on strobe, drive only reads
// [R21] undefined select codes change nothing
`timescale 1ns/1ps
module eprom_program_verify_port
  import eprom_port_pkg::*;
#(
  parameter int CODE_DEPTH = 16384
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // programming pins
  input wire logic reset_level_in,
  input wire logic program_store_enable_n_in,
  input wire logic latch_program_strobe_n_in,
  input wire logic prog_supply_high_in,
  input wire logic [4:0] mode_select_in,
  input wire logic [13:0] address_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // erase and lock effects
  input wire logic erase_in,
  output logic ext_code_read_block_out,
  output logic prog_inhibit_out,
  output logic verify_inhibit_out,
  output logic ext_exec_inhibit_out
);
  mode_t mode;
  logic [7:0] code_mem [CODE_DEPTH];
  logic [7:0] key_r [KEY_DEPTH];
  logic [7:0] key_nxt [KEY_DEPTH];
  logic [2:0] lock_r;
  logic [2:0] lock_nxt;
  logic strobe_d_r;
  logic strobe_fall;
  logic write_en;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [7:0] key_sel;

  // [R2] [R4]
  prog_mode_decode u_decode (
    .reset_level_in(reset_level_in),
    .program_store_enable_n_in(program_store_enable_n_in),
    .mode_select_in(mode_select_in),
    .mode_out(mode)
  );

  // one write per falling strobe edge; repeated pulses rewrite same value
  assign strobe_fall = strobe_d_r && !latch_program_strobe_n_in;
  assign write_en = strobe_fall && prog_supply_high_in && !lock_r[0]; // [R7] [R20] [R19]

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_d_r <= 1'b1;
    end else begin
      strobe_d_r <= latch_program_strobe_n_in;
    end
  end

  // code array: plain memory, no reset; erase_in only blocks writes and never clears it
  always_ff @(posedge core_clk_in) begin
    if (write_en && mode == MODE_PROG_CODE && !erase_in) begin
      code_mem[address_in] <= data_in; // [R6] [R5]
    end
  end

  // key array and lock bits
  always_comb begin
    for (int i = 0; i < KEY_DEPTH; i++) begin
      key_nxt[i] = key_r[i];
    end
    lock_nxt = lock_r;
    if (erase_in) begin
      for (int i = 0; i < KEY_DEPTH; i++) begin
        key_nxt[i] = ERASED_BYTE; // [R14] [R16]
      end
      lock_nxt = 3'h0; // [R14]
    end else if (write_en) begin
      case (mode)
        MODE_PROG_KEY: key_nxt[address_in[KEY_W-1:0]] = data_in; // [R11]
        MODE_LOCK_1: lock_nxt[0] = 1'b1; // [R12]
        MODE_LOCK_2: lock_nxt[1] = 1'b1;
        MODE_LOCK_3: lock_nxt[2] = 1'b1;
        default: lock_nxt = lock_r; // [R21]
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < KEY_DEPTH; i++) begin
        key_r[i] <= ERASED_BYTE; // [R16]
      end
      lock_r <= 3'h0;
    end else begin
      key_r <= key_nxt;
      lock_r <= lock_nxt;
    end
  end

  // read path
  assign key_sel = key_r[address_in[KEY_W-1:0]]; // [R15]

  always_comb begin
    data_nxt = 8'h00;
    oe_nxt = 1'b0;
    case (mode)
      MODE_VERIFY: begin
        // [R19] verify blocked once lock bit 2 is set
        if (!lock_r[1] && latch_program_strobe_n_in) begin
          data_nxt = ~(code_mem[address_in] ^ key_sel); // [R15] [R10]
          oe_nxt = 1'b1; // [R3] [R20]
        end
      end
      MODE_SIGNATURE: begin
        oe_nxt = 1'b1; // [R17]
        case (address_in)
          SIG_ADDR_0: data_nxt = SIG_BYTE_0; // [R18]
          SIG_ADDR_1: data_nxt = SIG_BYTE_1;
          SIG_ADDR_2: data_nxt = SIG_BYTE_2;
          default: data_nxt = 8'h00;
        endcase
      end
      default: begin
        data_nxt = 8'h00;
        oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_r <= 8'h00;
      oe_r <= 1'b0;
    end else begin
      data_r <= data_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign data_out = data_r;
  assign data_oe_out = oe_r;
  // lock bits have no read path, only their effects show [R13]
  assign ext_code_read_block_out = lock_r[0]; // [R19]
  assign prog_inhibit_out = lock_r[0];
  assign verify_inhibit_out = lock_r[0] && lock_r[1];
  assign ext_exec_inhibit_out = lock_r[0] && lock_r[1] && lock_r[2];

  // assertions
  sequence strobe_write_s;
    strobe_d_r && !latch_program_strobe_n_in && prog_supply_high_in && !lock_r[0];
  endsequence

  no_drive_idle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R20]
    (mode != MODE_VERIFY && mode != MODE_SIGNATURE) |=> !data_oe_out)
    else $error("data lines driven outside read modes");
  sig_byte_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R18]
    (mode == MODE_SIGNATURE && address_in == SIG_ADDR_0) |=> data_out == SIG_BYTE_0)
    else $error("wrong signature byte");
  sig_second_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R18]
    (mode == MODE_SIGNATURE && address_in == SIG_ADDR_1) |=> data_out == SIG_BYTE_1)
    else $error("wrong second signature byte");
  sig_third_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R18]
    (mode == MODE_SIGNATURE && address_in == SIG_ADDR_2) |=> data_out == SIG_BYTE_2)
    else $error("wrong third signature byte");
  lock_one_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R12]
    ((mode == MODE_LOCK_1 && !erase_in) and strobe_write_s) |=> lock_r[0])
    else $error("lock bit 1 not set");
  lock_two_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R12]
    ((mode == MODE_LOCK_2 && !erase_in) and strobe_write_s) |=> lock_r[1])
    else $error("lock bit 2 not set");
  lock_three_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R12]
    ((mode == MODE_LOCK_3 && !erase_in) and strobe_write_s) |=> lock_r[2])
    else $error("lock bit 3 not set");
  prog_lock_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R19]
    (lock_r[0] && !erase_in) |=> lock_r[0] && $stable(lock_r))
    else $error("lock state changed while programming inhibited");
  lock_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R21]
    (!erase_in && !strobe_fall) |=> $stable(lock_r))
    else $error("lock changed without strobe");
  erase_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R14]
    erase_in |=> lock_r == 3'h0 && key_r[0] == ERASED_BYTE)
    else $error("erase left lock or key state");
  verify_lock_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R19]
    (mode == MODE_VERIFY && lock_r[1]) |=> !data_oe_out)
    else $error("verify output while locked");
  verify_oe_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R10]
    (mode == MODE_VERIFY && !lock_r[1] && latch_program_strobe_n_in) |=> data_oe_out)
    else $error("verify did not drive data lines");
  key_write_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R11]
    ((mode == MODE_PROG_KEY && !erase_in) and strobe_write_s) |=>
      key_r[$past(address_in[KEY_W-1:0])] == $past(data_in))
    else $error("key byte not written");
  verify_data_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R15]
    (mode == MODE_VERIFY && !lock_r[1] && latch_program_strobe_n_in) ##1 data_oe_out
      |-> data_out == $past(~(code_mem[address_in] ^ key_sel)))
    else $error("verify byte not code xnor key");
endmodule

// [verification/eprom_programmer.sv]
// external programmer model driving the eprom port pins
`timescale 1ns/1ps
module eprom_programmer
  import eprom_port_pkg::*;
(
  // clock and device read side
  input wire logic clk_in,
  input wire logic [7:0] dev_data_in,
  input wire logic dev_oe_in,
  // pins driven toward the device
  output logic strobe_n_out,
  output logic supply_out,
  output logic [4:0] sel_out,
  output logic [13:0] addr_out,
  output logic [7:0] data_out
);
  // idles on an undefined select code, so no read of unwritten code is launched
  localparam logic [4:0] SEL_IDLE = 5'h03;
  // runs on the 25 mhz bench clock, a real programmer keeps 4 to 6 mhz
  initial begin
    strobe_n_out = 1'b1;
    supply_out = 1'b0;
    sel_out = SEL_IDLE;
    addr_out = '0;
    data_out = '0;
  end
  task automatic write(input logic [4:0] sel, input logic [13:0] a, input logic [7:0] d,
                       input int n);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
    sel_out <= sel;
    @(posedge clk_in);
    supply_out <= 1'b1;
    repeat (n) begin
      @(posedge clk_in);
      strobe_n_out <= 1'b0;
      @(posedge clk_in);
      strobe_n_out <= 1'b1;
      repeat (2) @(posedge clk_in);
    end
    supply_out <= 1'b0;
  endtask
  task automatic read(input logic [4:0] sel, input logic [13:0] a, output logic [7:0] d,
                      output logic oe);
    @(posedge clk_in);
    sel_out <= sel;
    addr_out <= a;
    // released data lines show the inverse so a stale byte is never mistaken for a read
    data_out <= ~data_out;
    repeat (2) @(posedge clk_in);
    #1;
    d = dev_data_in;
    oe = dev_oe_in;
  endtask
endmodule

// [verification/tb.sv]
// self-checking testbench for the eprom program and verify port
`timescale 1ns/1ps
module tb;
  import eprom_port_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic erase_in = 1'b0;
  logic reset_level = 1'b1;
  logic store_en_n = 1'b0;
  logic strobe_n, supply, oe, lk1, lk2, lk3, lk4, o;
  logic [4:0] sel;
  logic [13:0] addr;
  logic [7:0] wdata, rdata, d;
  int error_cnt = 0;
  int tests_run = 0;
  always #20 core_clk_in = ~core_clk_in;
  eprom_programmer u_prog (.clk_in(core_clk_in), .dev_data_in(rdata), .dev_oe_in(oe),
    .strobe_n_out(strobe_n), .supply_out(supply), .sel_out(sel), .addr_out(addr),
    .data_out(wdata));
  // reset pin and store enable sit at programming levels unless a scenario moves them
  eprom_program_verify_port u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .reset_level_in(reset_level), .program_store_enable_n_in(store_en_n),
    .latch_program_strobe_n_in(strobe_n), .prog_supply_high_in(supply),
    .mode_select_in(sel), .address_in(addr), .data_in(wdata), .data_out(rdata),
    .data_oe_out(oe), .erase_in(erase_in), .ext_code_read_block_out(lk1),
    .prog_inhibit_out(lk2), .verify_inhibit_out(lk3), .ext_exec_inhibit_out(lk4));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [4:0] s, input logic [13:0] a, input logic [7:0] exp,
                    input logic exp_oe);
    u_prog.read(s, a, d, o);
    chk("oe", {7'h0, exp_oe}, {7'h0, o});
    if (exp_oe === 1'b1) chk("data", exp, d);
  endtask
  task automatic t_code();
    u_prog.write(SEL_PROG_CODE, 14'h3fc5, 8'ha5, 5);
    u_prog.write(SEL_PROG_CODE, 14'h0005, 8'h3c, 5);
    rd(SEL_VERIFY, 14'h3fc5, 8'ha5, 1'b1);
    rd(SEL_VERIFY, 14'h0005, 8'h3c, 1'b1);
    rd(SEL_PROG_CODE, 14'h0005, 8'h00, 1'b0);
    $display("test code done");
  endtask
  task automatic t_key();
    u_prog.write(SEL_PROG_KEY, 14'h0005, 8'h0f, 25);
    rd(SEL_VERIFY, 14'h3fc5, ~(8'ha5 ^ 8'h0f), 1'b1);
    rd(SEL_VERIFY, 14'h0005, ~(8'h3c ^ 8'h0f), 1'b1);
    u_prog.write(5'h03, 14'h0005, 8'h00, 5);
    rd(SEL_VERIFY, 14'h0005, ~(8'h3c ^ 8'h0f), 1'b1);
    $display("test key done");
  endtask
  task automatic t_sig();
    rd(SEL_SIGNATURE, SIG_ADDR_0, SIG_BYTE_0, 1'b1);
    rd(SEL_SIGNATURE, SIG_ADDR_1, SIG_BYTE_1, 1'b1);
    rd(SEL_SIGNATURE, SIG_ADDR_2, SIG_BYTE_2, 1'b1);
    // off the programming levels of reset pin or store enable no mode is entered
    @(posedge core_clk_in);
    store_en_n <= 1'b1;
    rd(SEL_SIGNATURE, SIG_ADDR_0, 8'h00, 1'b0);
    @(posedge core_clk_in);
    store_en_n <= 1'b0;
    reset_level <= 1'b0;
    rd(SEL_SIGNATURE, SIG_ADDR_0, 8'h00, 1'b0);
    @(posedge core_clk_in);
    reset_level <= 1'b1;
    $display("test signature done");
  endtask
  task automatic t_lock();
    // lock 1 blocks further writes, so it goes last
    u_prog.write(SEL_LOCK_3, 14'h0000, 8'h00, 25);
    u_prog.write(SEL_LOCK_2, 14'h0000, 8'h00, 25);
    chk("locks", 8'h00, {4'h0, lk1, lk2, lk3, lk4});
    u_prog.write(SEL_LOCK_1, 14'h0000, 8'h00, 25);
    chk("locks", 8'h0f, {4'h0, lk1, lk2, lk3, lk4});
    rd(SEL_VERIFY, 14'h0005, 8'h00, 1'b0);
    u_prog.write(SEL_PROG_CODE, 14'h0005, 8'h77, 5);
    $display("test lock done");
  endtask
  task automatic t_erase();
    @(posedge core_clk_in);
    erase_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    erase_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    chk("locks", 8'h00, {4'h0, lk1, lk2, lk3, lk4});
    rd(SEL_VERIFY, 14'h3fc5, 8'ha5, 1'b1);
    rd(SEL_VERIFY, 14'h0005, 8'h3c, 1'b1);
    $display("test erase done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_code();
    t_key();
    t_sig();
    t_lock();
    t_erase();
    conclude();
  end
  // whole run needs well under 30 us; a hang is cut off long after that
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
endmodule
